// File: src/downstream_protection.sv
// Downstream protection: power detector, transmit sequencer, blanking,
// gain ramp and protect pin generation.
// Assumes samples and register strobes on i_clk; the pin inputs are async.
`timescale 1ns/1ps
module downstream_protection
    import protect_pkg::*;
#(
    parameter int SEQ_DELAY  = SEQ_DELAY_CYC,
    parameter int LINK_ERRS  = 16
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic [11:0]          i_reg_addr,
    input  wire logic [7:0]           i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output logic      [7:0]           o_reg_rdata,
    input  wire logic [15:0]          i_sample_i,
    input  wire logic [15:0]          i_sample_q,
    input  wire logic                 i_sample_valid,
    input  wire logic                 i_transmit_enable,
    input  wire logic [LINK_ERRS-1:0] i_link_errors,
    input  wire logic                 i_spi_write_error,
    input  wire logic                 i_dig_gain_en,
    input  wire logic [11:0]          i_gain_code,
    output logic      [11:0]          o_gain_applied,
    output logic                      o_core_powerdown,
    output logic                      o_clock_powerdown,
    output logic                      o_datapath_flush,
    output logic                      o_power_irq_source,
    output logic                      o_protect_out
);

    // ==========================================================
    // Elaboration checks
    if (SEQ_DELAY < 1) begin : g_bad_delay
        $error("SEQ_DELAY must be at least one cycle");
    end
    if (LINK_ERRS < 1 || LINK_ERRS > 16) begin : g_bad_errs
        $error("LINK_ERRS must be 1 to 16");
    end

    // ==========================================================
    // Register file
    logic [7:0]  masks_r, pin_sel_r, irq_en_r, lim_lo_r, lim_hi_r, det_ctl_r;
    logic [7:0]  link_lo_r, link_hi_r, seq_ctl_r, spi_err_r, pmode_r;
    logic [7:0]  up_lo_r, up_hi_r, dn_lo_r, dn_hi_r;
    logic        irq_clear;
    logic [12:0] limit;
    logic [12:0] readback;
    logic        irq_status;

    assign limit     = {lim_hi_r[4:0], lim_lo_r};
    assign irq_clear = i_reg_wr && i_reg_addr == ADDR_IRQ_STAT && i_reg_wdata[BIT_PWR_IRQ];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            masks_r   <= REG_RESET;
            pin_sel_r <= REG_RESET;
            irq_en_r  <= REG_RESET;
            lim_lo_r  <= REG_RESET;
            lim_hi_r  <= REG_RESET;
            det_ctl_r <= REG_RESET;
            link_lo_r <= REG_RESET;
            link_hi_r <= REG_RESET;
            seq_ctl_r <= REG_RESET;
            spi_err_r <= REG_RESET;
            pmode_r   <= REG_RESET;
            up_lo_r   <= REG_RESET;
            up_hi_r   <= REG_RESET;
            dn_lo_r   <= REG_RESET;
            dn_hi_r   <= REG_RESET;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_MASKS:     masks_r   <= i_reg_wdata;
                ADDR_PIN_SEL:   pin_sel_r <= i_reg_wdata;
                ADDR_IRQ_EN:    irq_en_r  <= i_reg_wdata;
                ADDR_LIMIT_LO:  lim_lo_r  <= i_reg_wdata;
                ADDR_LIMIT_HI:  lim_hi_r  <= {3'h0, i_reg_wdata[4:0]};
                ADDR_DET_CTL:   det_ctl_r <= i_reg_wdata;
                ADDR_LINK_M_LO: link_lo_r <= i_reg_wdata;
                ADDR_LINK_M_HI: link_hi_r <= i_reg_wdata;
                ADDR_SEQ_CTL:   seq_ctl_r <= i_reg_wdata;
                ADDR_SPI_ERR:   spi_err_r <= i_reg_wdata;
                ADDR_PMODE:     pmode_r   <= i_reg_wdata;
                ADDR_UP_LO:     up_lo_r   <= i_reg_wdata;
                ADDR_UP_HI:     up_hi_r   <= i_reg_wdata;
                ADDR_DN_LO:     dn_lo_r   <= i_reg_wdata;
                ADDR_DN_HI:     dn_hi_r   <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read data is registered; unmapped offsets answer zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_MASKS:     o_reg_rdata <= masks_r;
                ADDR_PIN_SEL:   o_reg_rdata <= pin_sel_r;
                ADDR_IRQ_EN:    o_reg_rdata <= irq_en_r;
                ADDR_IRQ_STAT:  o_reg_rdata <= {irq_status, 7'h00};
                ADDR_LIMIT_LO:  o_reg_rdata <= lim_lo_r;
                ADDR_LIMIT_HI:  o_reg_rdata <= lim_hi_r;
                ADDR_DET_CTL:   o_reg_rdata <= det_ctl_r;
                ADDR_POWER_LO:  o_reg_rdata <= readback[7:0];
                ADDR_POWER_HI:  o_reg_rdata <= {3'h0, readback[12:8]};
                ADDR_LINK_M_LO: o_reg_rdata <= link_lo_r;
                ADDR_LINK_M_HI: o_reg_rdata <= link_hi_r;
                ADDR_SEQ_CTL:   o_reg_rdata <= seq_ctl_r;
                ADDR_SPI_ERR:   o_reg_rdata <= spi_err_r;
                ADDR_PMODE:     o_reg_rdata <= pmode_r;
                ADDR_UP_LO:     o_reg_rdata <= up_lo_r;
                ADDR_UP_HI:     o_reg_rdata <= up_hi_r;
                ADDR_DN_LO:     o_reg_rdata <= dn_lo_r;
                ADDR_DN_HI:     o_reg_rdata <= dn_hi_r;
                default:        o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Power detector
    // Works on raw input samples, ahead of the interpolating datapath,
    // so the flag can act before the same samples reach the cores.
    function automatic logic [10:0] square6(input logic [SAMPLE_BITS-1:0] s);
        logic [SAMPLE_BITS-1:0] mag;
        mag = s[SAMPLE_BITS-1] ? 6'(-s) : s;
        if (s == 6'h20) begin
            square6 = 11'h400;
        end else begin
            square6 = 11'({5'h00, mag} * {5'h00, mag});
        end
    endfunction

    logic        det_on;
    logic [3:0]  avg_exp;
    logic [4:0]  avg_shift;
    logic [11:0] sample_power;
    logic [30:0] acc_r, acc_sum;
    logic [18:0] cnt_r, cnt_last;
    logic [11:0] avg_nxt;
    logic        win_end;
    logic        pwr_flag_r, pwr_flag_d_r, crossed_r;
    logic [11:0] inst_r, max_r;
    logic        irq_src_r;

    assign det_on       = det_ctl_r[BIT_DET_ON];
    assign avg_exp      = det_ctl_r[3:0] > 4'(AVG_EXP_MAX) ? 4'(AVG_EXP_MAX) : det_ctl_r[3:0];
    assign avg_shift    = 5'(AVG_BASE_EXP) + {1'b0, avg_exp};
    assign sample_power = 12'(square6(i_sample_i[15:10])) + 12'(square6(i_sample_q[15:10]));
    assign acc_sum      = acc_r + 31'(sample_power);
    assign cnt_last     = 19'((32'd1 << avg_shift) - 32'd1);
    assign win_end      = cnt_r == cnt_last;
    assign avg_nxt      = 12'(acc_sum >> avg_shift);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r      <= 31'h0;
            cnt_r      <= 19'h0;
            pwr_flag_r <= 1'b0;
            crossed_r  <= 1'b0;
            max_r      <= 12'h000;
        end else if (!det_on) begin
            acc_r      <= 31'h0;
            cnt_r      <= 19'h0;
            pwr_flag_r <= 1'b0;
            crossed_r  <= 1'b0;
            max_r      <= 12'h000;
        end else if (i_sample_valid) begin
            if (win_end) begin
                acc_r      <= 31'h0;
                cnt_r      <= 19'h0;
                pwr_flag_r <= {1'b0, avg_nxt} > limit;
                if ({1'b0, avg_nxt} > limit) begin
                    crossed_r <= 1'b1;
                    if (!crossed_r || avg_nxt > max_r) begin
                        max_r <= avg_nxt;
                    end
                end
            end else begin
                acc_r <= acc_sum;
                cnt_r <= cnt_r + 19'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            inst_r <= 12'h000;
        end else if (i_sample_valid) begin
            inst_r <= sample_power;
        end
    end

    assign readback = crossed_r ? {1'b0, max_r} : {1'b0, inst_r};

    // Sticky source only while enabled; a new rise beats a same-cycle clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_flag_d_r <= 1'b0;
            irq_src_r    <= 1'b0;
        end else begin
            pwr_flag_d_r <= pwr_flag_r;
            if (!irq_en_r[BIT_PWR_IRQ]) begin
                irq_src_r <= 1'b0;
            end else if (pwr_flag_r && !pwr_flag_d_r) begin
                irq_src_r <= 1'b1;
            end else if (irq_clear) begin
                irq_src_r <= 1'b0;
            end
        end
    end

    assign irq_status         = irq_en_r[BIT_PWR_IRQ] ? irq_src_r : pwr_flag_r;
    assign o_power_irq_source = irq_src_r;

    // ==========================================================
    // Transmit enable source and sequencer
    logic       transmit_enable_meta_r, transmit_enable_sync_r, transmit_enable_d_r;
    logic       transmit_enable_eff, tx_fall, tx_rise, seq_on;
    seq_state_e seq_r;
    logic [15:0] seq_cnt_r;
    logic       tx_guard;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            transmit_enable_meta_r <= 1'b0;
            transmit_enable_sync_r <= 1'b0;
            transmit_enable_d_r    <= 1'b0;
        end else begin
            transmit_enable_meta_r <= i_transmit_enable;
            transmit_enable_sync_r <= transmit_enable_meta_r;
            transmit_enable_d_r    <= transmit_enable_eff;
        end
    end

    assign transmit_enable_eff = pin_sel_r[BIT_TX_SEL] ? pin_sel_r[BIT_TX_VAL] : transmit_enable_sync_r;
    assign tx_fall  = transmit_enable_d_r && !transmit_enable_eff;
    assign tx_rise  = !transmit_enable_d_r && transmit_enable_eff;
    assign seq_on   = seq_ctl_r[BIT_SEQ_ON];

    // Falling edge: guard first, power down after the delay.
    // Rising edge: power up at once, release guard after the delay.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_r     <= SEQ_ON;
            seq_cnt_r <= 16'h0;
        end else if (!seq_on) begin
            seq_r     <= SEQ_ON;
            seq_cnt_r <= 16'h0;
        end else begin
            case (seq_r)
                SEQ_ON: begin
                    if (tx_fall) begin
                        seq_r     <= SEQ_DOWN;
                        seq_cnt_r <= 16'h0;
                    end
                end
                SEQ_DOWN: begin
                    if (tx_rise) begin
                        seq_r     <= SEQ_WAKE;
                        seq_cnt_r <= 16'h0;
                    end else if (seq_cnt_r == 16'(SEQ_DELAY - 1)) begin
                        seq_r <= SEQ_OFF;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 16'h1;
                    end
                end
                SEQ_OFF: begin
                    if (tx_rise) begin
                        seq_r     <= SEQ_WAKE;
                        seq_cnt_r <= 16'h0;
                    end
                end
                SEQ_WAKE: begin
                    if (tx_fall) begin
                        seq_r     <= SEQ_DOWN;
                        seq_cnt_r <= 16'h0;
                    end else if (seq_cnt_r == 16'(SEQ_DELAY - 1)) begin
                        seq_r <= SEQ_ON;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 16'h1;
                    end
                end
                default: seq_r <= SEQ_ON;
            endcase
        end
    end

    assign tx_guard = seq_r != SEQ_ON;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_powerdown  <= 1'b0;
            o_clock_powerdown <= 1'b0;
        end else begin
            o_core_powerdown  <= seq_r == SEQ_OFF && masks_r[BIT_CORE_MASK] && !tx_rise;
            o_clock_powerdown <= seq_r == SEQ_OFF && masks_r[BIT_CLK_MASK] && !tx_rise;
        end
    end

    // ==========================================================
    // Blanking and shutdown sources
    logic blank_guard, blank_d_r;
    logic intf_guard, spi_guard, pwr_shut, shutdown;

    assign blank_guard = !transmit_enable_eff;
    assign intf_guard  = |(i_link_errors & LINK_ERRS'({link_hi_r, link_lo_r}));
    assign spi_guard   = i_spi_write_error && spi_err_r[BIT_SD_SPI];
    assign pwr_shut    = pmode_r[BIT_SD_AVG] && pwr_flag_r;
    assign shutdown    = blank_guard ||
                         (pmode_r[BIT_PMODE] && (pwr_shut || intf_guard || spi_guard));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Blanking is already active out of reset, so no flush edge follows it
            blank_d_r        <= 1'b1;
            o_datapath_flush <= 1'b0;
        end else begin
            blank_d_r        <= blank_guard;
            o_datapath_flush <= blank_guard && !blank_d_r;
        end
    end

    // ==========================================================
    // Gain ramp
    // Without the gain stage the ramp cannot act, so the code passes through.
    logic [15:0] step_up, step_dn;
    logic [11:0] target;
    logic [16:0] gain_up, gain_dn;

    assign step_up = {up_hi_r, up_lo_r};
    assign step_dn = {dn_hi_r, dn_lo_r};
    assign target  = shutdown ? 12'h000 : i_gain_code;
    assign gain_up = {5'h0, o_gain_applied} + {1'b0, step_up};
    assign gain_dn = {5'h0, o_gain_applied} - {1'b0, step_dn};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gain_applied <= GAIN_RESET;
        end else if (!i_dig_gain_en) begin
            o_gain_applied <= i_gain_code;
        end else if (o_gain_applied < target) begin
            o_gain_applied <= gain_up >= {5'h0, target} ? target : gain_up[11:0];
        end else if (o_gain_applied > target) begin
            o_gain_applied <= (gain_dn[16] || gain_dn[11:0] <= target) ? target
                                                                       : gain_dn[11:0];
        end
    end

    // ==========================================================
    // Protect pin
    logic any_src;

    assign any_src = (pwr_flag_r  && pin_sel_r[BIT_RT_PWR])   ||
                     (tx_guard    && pin_sel_r[BIT_RT_TX])    ||
                     (blank_guard && pin_sel_r[BIT_RT_BLANK]) ||
                     (spi_guard   && pin_sel_r[BIT_RT_SPI]);

    // High means output valid unless inverted
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_protect_out <= 1'b0;
        end else if (pin_sel_r[BIT_PIN_LOW]) begin
            o_protect_out <= 1'b0;
        end else begin
            o_protect_out <= seq_ctl_r[BIT_PIN_INV] ? any_src : !any_src;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_det_off_quiet: assert property (!det_on |=> !pwr_flag_r && acc_r == 31'h0)
        else $error("Detector off but flag or accumulator active");
    a_det_flag_set: assert property (det_on && i_sample_valid && win_end &&
        ({1'b0, avg_nxt} > limit) |=> pwr_flag_r || !det_on)
        else $error("Average above limit did not raise flag");
    a_det_needs_on: assert property ($rose(pwr_flag_r) |-> $past(det_on))
        else $error("Flag rose with detector off");
    a_max_holds: assert property (crossed_r && $past(crossed_r) |-> max_r >= $past(max_r))
        else $error("Maximum power decreased");
    a_irq_sticky: assert property (irq_en_r[BIT_PWR_IRQ] && $rose(pwr_flag_r)
        |=> irq_src_r)
        else $error("Overrange event not latched");
    a_seq_idle_off: assert property (!seq_on |=> seq_r == SEQ_ON && !tx_guard)
        else $error("Sequencer active while disabled");
    a_core_pd_cause: assert property ($rose(o_core_powerdown) |->
        $past(masks_r[BIT_CORE_MASK]) && $past(seq_r) == SEQ_OFF)
        else $error("Core powered down without masked fall");
    a_core_wake: assert property (seq_r == SEQ_OFF && tx_rise && seq_on
        |=> !o_core_powerdown && !o_clock_powerdown)
        else $error("Cores not powered up on rise");
    a_clk_pd_cause: assert property ($rose(o_clock_powerdown) |->
        $past(masks_r[BIT_CLK_MASK]))
        else $error("Clock powered down without mask");
    a_tx_select: assert property (pin_sel_r[BIT_TX_SEL] |-> transmit_enable_eff == pin_sel_r[BIT_TX_VAL])
        else $error("Register transmit enable ignored");
    a_pin_force: assert property (pin_sel_r[BIT_PIN_LOW] |=> !o_protect_out)
        else $error("Protect pin not forced low");
    a_pin_level: assert property (!pin_sel_r[BIT_PIN_LOW] && !seq_ctl_r[BIT_PIN_INV] && any_src
        |=> !o_protect_out)
        else $error("Routed source did not drop the pin");
    a_ramp_down: assert property (i_dig_gain_en && shutdown && o_gain_applied != 12'h000
        && step_dn != 16'h0000 && $stable(i_dig_gain_en)
        |=> o_gain_applied < $past(o_gain_applied))
        else $error("Gain not ramping down in shutdown");

    c_power_trip: cover property ($rose(pwr_flag_r));
    c_seq_cycle:  cover property (seq_r == SEQ_OFF ##[1:200] seq_r == SEQ_ON);
    c_gain_zero:  cover property (shutdown && o_gain_applied == 12'h000);
    c_pin_drop:   cover property ($fell(o_protect_out));

endmodule

// File: src/protect_pkg.sv
// Constants for the downstream protection block: register map, fields,
// reset values and sequencer timing.
// Assumes a byte-wide register port from the serial-port decoder.
//
// Contract
// - Power is I squared plus Q squared, six MSBs
// - Average over 2^(9+exp) pairs, exp 0..10
// - Overrange flag high when average exceeds limit
// - Limit is 13 bits over 0x060 and 0x061
// - Detector runs only while 0x062 bit 7 set
// - Readback shows max after crossing, else instantaneous
// - Detector path shorter than main datapath latency
// - Protect mode plus avg-power bit shuts output
// - Overrange is interrupt event at 0x021/0x025 bit 7
// - Sequencer delays guard and makes power-down controls
// - Core mask: TX fall powers cores down, rise up
// - Clock mask: TX fall powers clock down, rise up
// - Sequencer runs only while 0x11F bit 0 high
// - Blanking follows TX enable, flushes, ramps gain
// - Each protect source ramps gain down to zero; sequencer guard does not, power, link, SPI only in protect mode
// - Ramp steps from 0x140/0x141 and 0x142/0x143
// - Link and serial-write errors may shut output
// - Protect pin ORs sources enabled in 0x013
// - 0x11F bit 2 inverts protect pin polarity
// - 0x013 bit 2 forces protect pin low
// - 0x013 bit 1 selects register TX enable, bit 0 value
package protect_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [11:0] ADDR_MASKS     = 12'h012;
    localparam logic [11:0] ADDR_PIN_SEL   = 12'h013;
    localparam logic [11:0] ADDR_IRQ_EN    = 12'h021;
    localparam logic [11:0] ADDR_IRQ_STAT  = 12'h025;
    localparam logic [11:0] ADDR_LIMIT_LO  = 12'h060;
    localparam logic [11:0] ADDR_LIMIT_HI  = 12'h061;
    localparam logic [11:0] ADDR_DET_CTL   = 12'h062;
    localparam logic [11:0] ADDR_POWER_LO  = 12'h063;
    localparam logic [11:0] ADDR_POWER_HI  = 12'h064;
    localparam logic [11:0] ADDR_LINK_M_LO = 12'h065;
    localparam logic [11:0] ADDR_LINK_M_HI = 12'h066;
    localparam logic [11:0] ADDR_SEQ_CTL   = 12'h11f;
    localparam logic [11:0] ADDR_SPI_ERR   = 12'h125;
    localparam logic [11:0] ADDR_PMODE     = 12'h12c;
    localparam logic [11:0] ADDR_UP_LO     = 12'h140;
    localparam logic [11:0] ADDR_UP_HI     = 12'h141;
    localparam logic [11:0] ADDR_DN_LO     = 12'h142;
    localparam logic [11:0] ADDR_DN_HI     = 12'h143;

    // ==========================================================
    // Field positions
    localparam int BIT_CORE_MASK  = 6;
    localparam int BIT_CLK_MASK   = 4;
    localparam int BIT_RT_PWR     = 6;
    localparam int BIT_RT_TX      = 5;
    localparam int BIT_RT_BLANK   = 4;
    localparam int BIT_RT_SPI     = 3;
    localparam int BIT_PIN_LOW    = 2;
    localparam int BIT_TX_SEL     = 1;
    localparam int BIT_TX_VAL     = 0;
    localparam int BIT_DET_ON     = 7;
    localparam int BIT_PWR_IRQ    = 7;
    localparam int BIT_SEQ_ON     = 0;
    localparam int BIT_PIN_INV    = 2;
    localparam int BIT_PMODE      = 7;
    localparam int BIT_SD_AVG     = 0;
    localparam int BIT_SD_SPI     = 0;

    // ==========================================================
    // Reset values and detector figures
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [11:0] GAIN_RESET    = 12'h800;
    localparam int          AVG_BASE_EXP  = 9;
    localparam int          AVG_EXP_MAX   = 10;
    localparam int          SAMPLE_BITS   = 6;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SEQ_DELAY_NS  = 1600;
    localparam int SEQ_DELAY_CYC = (SEQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SEQ_ON   = 2'b00,
        SEQ_DOWN = 2'b01,
        SEQ_OFF  = 2'b11,
        SEQ_WAKE = 2'b10
    } seq_state_e;

endpackage

// File: verification/pa_model.sv
// Power amplifier partner: follows the protect pin.
// Assumes the pin is high while the converter output is valid.
`timescale 1ns/1ps
module pa_model (
    input  wire logic i_clk,
    input  wire logic i_protect,
    output logic      o_pa_on
);
    // ==========================================================
    // Output stage
    // Keyed on the clock so a one-cycle drop is never missed
    always_ff @(posedge i_clk) begin
        o_pa_on <= i_protect;
    end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the downstream protection block.
// Assumes protect_pkg and a pa_model partner on the protect pin.
`timescale 1ns/1ps
module testbench;
    import protect_pkg::*;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, sv = 0;
    logic [11:0] addr = '0, gain;
    logic [7:0]  wd = '0, rdata;
    logic [15:0] si = '0;
    logic        cpd, kpd, pin, pa_on, flush, irq;
    logic        transmit_enable = 1;
    int          n_fail = 0, comparisons = 0;
    always #50 clk = ~clk;
    downstream_protection #(.SEQ_DELAY(2)) i_downstream_protection (
        .i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_sample_i(si),
        .i_sample_q(si), .i_sample_valid(sv), .i_transmit_enable(transmit_enable),
        .i_link_errors(16'h0000), .i_spi_write_error(1'b0), .i_dig_gain_en(1'b1),
        .i_gain_code(12'h800), .o_gain_applied(gain), .o_core_powerdown(cpd),
        .o_clock_powerdown(kpd), .o_datapath_flush(flush), .o_power_irq_source(irq),
        .o_protect_out(pin));
    pa_model i_pa_model (.i_clk(clk), .i_protect(pin), .o_pa_on(pa_on));
    // ==========================================================
    // Shared tasks
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(logic [11:0] a, logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
        @(negedge clk);
    endtask
    task automatic rreg(logic [11:0] a, logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        @(negedge clk);
        chk("rdata", 16'(e), 16'(rdata));
    endtask
    // One window of 512 pairs, top six bits = 1, so each power is 2
    task automatic feed;
        si = 16'h0400;
        sv = 1;
        repeat (512) @(negedge clk);
        sv = 0;
        repeat (2) @(negedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        chk("pin", 16'h1, 16'(pin));
        rreg(ADDR_LIMIT_LO, 8'h00);
        wreg(ADDR_LIMIT_LO, 8'h5a);
        wreg(ADDR_LIMIT_HI, 8'h1f);
        rreg(ADDR_LIMIT_LO, 8'h5a);
        rreg(ADDR_LIMIT_HI, 8'h1f);
        wreg(ADDR_POWER_LO, 8'hff);
        rreg(ADDR_POWER_LO, 8'h00);
        rreg(12'h3ff, 8'h00);
    endtask
    task automatic t_pin;
        wreg(ADDR_SEQ_CTL, 8'h04);
        chk("pin", 16'h0, 16'(pin));
        wreg(ADDR_SEQ_CTL, 8'h00);
        wreg(ADDR_PIN_SEL, 8'h04);
        chk("pin", 16'h0, 16'(pin));
        @(negedge clk);
        chk("pa_on", 16'h0, 16'(pa_on));
        wreg(ADDR_PIN_SEL, 8'h00);
        chk("pin", 16'h1, 16'(pin));
    endtask
    task automatic t_seq;
        wreg(ADDR_MASKS, 8'h50);
        wreg(ADDR_PIN_SEL, 8'h02);
        repeat (8) @(negedge clk);
        chk("core_pd", 16'h0, 16'(cpd));
        wreg(ADDR_MASKS, 8'h00);
        wreg(ADDR_PIN_SEL, 8'h20);
        wreg(ADDR_UP_LO, 8'h04);
        wreg(ADDR_DN_LO, 8'h09);
        wreg(ADDR_SEQ_CTL, 8'h83);
        wreg(ADDR_MASKS, 8'h50);
        wreg(ADDR_PIN_SEL, 8'h03);
        wreg(ADDR_PIN_SEL, 8'h02);
        repeat (8) @(negedge clk);
        chk("core_pd", 16'h1, 16'(cpd));
        chk("clock_pd", 16'h1, 16'(kpd));
        repeat (230) @(negedge clk);
        chk("gain", 16'h0, 16'(gain));
        wreg(ADDR_PIN_SEL, 8'h03);
        chk("core_pd", 16'h0, 16'(cpd));
        chk("clock_pd", 16'h0, 16'(kpd));
        // Ramp up by 4 per cycle from zero: 501 steps seen here
        repeat (500) @(negedge clk);
        chk("gain", 16'h7d4, 16'(gain));
        repeat (20) @(negedge clk);
        chk("gain", 16'h800, 16'(gain));
        // Same fall and rise through the synchronised pin
        wreg(ADDR_PIN_SEL, 8'h20);
        transmit_enable = 0;
        repeat (3) @(negedge clk);
        chk("flush", 16'h1, 16'(flush));
        repeat (5) @(negedge clk);
        chk("core_pd", 16'h1, 16'(cpd));
        chk("pin", 16'h0, 16'(pin));
        transmit_enable = 1;
        repeat (8) @(negedge clk);
        chk("core_pd", 16'h0, 16'(cpd));
        chk("pin", 16'h1, 16'(pin));
    endtask
    task automatic t_det;
        wreg(ADDR_IRQ_EN, 8'h80);
        wreg(ADDR_PIN_SEL, 8'h43);
        wreg(ADDR_LIMIT_LO, 8'h02);
        wreg(ADDR_LIMIT_HI, 8'h00);
        wreg(ADDR_DET_CTL, 8'h80);
        feed();
        chk("pin", 16'h1, 16'(pin));
        wreg(ADDR_LIMIT_LO, 8'h01);
        feed();
        chk("pin", 16'h0, 16'(pin));
        rreg(ADDR_IRQ_STAT, 8'h80);
        rreg(ADDR_POWER_LO, 8'h02);
        chk("irq", 16'h1, 16'(irq));
        wreg(ADDR_IRQ_STAT, 8'h80);
        chk("irq", 16'h0, 16'(irq));
        wreg(ADDR_DET_CTL, 8'h00);
        @(negedge clk);
        chk("pin", 16'h1, 16'(pin));
    endtask
    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        repeat (2) @(negedge clk);
        t_regs();
        t_pin();
        t_seq();
        t_det();
        results();
    end
    // About 1920 cycles are needed; allow several times that
    initial begin
        #1000000;
        n_fail++;
        results();
    end
endmodule
